// [logic/bit_test_pkg.sv]
// constants, field layouts and types shared by the bit test and modify unit
`default_nettype none
package bit_test_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_OPCODE = 8'h00;
    localparam logic [7:0] OFS_IMM = 8'h04;
    localparam logic [7:0] OFS_OFFSET = 8'h08;
    localparam logic [7:0] OFS_BASE = 8'h0C;
    localparam logic [7:0] OFS_LIMIT = 8'h10;
    localparam logic [7:0] OFS_SEG = 8'h14;
    localparam logic [7:0] OFS_GO_STATUS = 8'h18;
    localparam logic [7:0] OFS_RESULT = 8'h1C;
    localparam logic [7:0] OFS_FAULT = 8'h20;
    localparam logic [7:0] OFS_FAULT_CODE = 8'h24;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h2C;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h30;

    // opcode bytes and group reg fields
    localparam logic [7:0] OP_ESCAPE = 8'h0F;
    localparam logic [7:0] OP2_TEST_REG = 8'hA3;
    localparam logic [7:0] OP2_COMPL_REG = 8'hBB;
    localparam logic [7:0] OP2_CLEAR_REG = 8'hB3;
    localparam logic [7:0] OP2_GROUP_IMM = 8'hBA;
    localparam logic [2:0] GRP_TEST = 3'h4;
    localparam logic [2:0] GRP_CLEAR = 3'h6;
    localparam logic [2:0] GRP_COMPL = 3'h7;

    // opcode register fields
    localparam int OPC_FIRST_LSB = 0;
    localparam int OPC_SECOND_LSB = 8;
    localparam int OPC_REGF_LSB = 16;
    localparam int OPC_WIDE_BIT = 24;
    localparam int OPC_MEMBASE_BIT = 25;

    // segment control register fields
    localparam int SEG_MODE_LSB = 0;
    localparam int SEG_STACK_BIT = 2;
    localparam int SEG_NULL_BIT = 3;
    localparam int SEG_WRITABLE_BIT = 4;
    localparam int SEG_ACEN_BIT = 5;
    localparam int SEG_CPL_LSB = 6;
    localparam logic [1:0] MODE_REAL = 2'h0;
    localparam logic [1:0] MODE_PROT = 2'h1;
    localparam logic [1:0] MODE_V86 = 2'h2;
    localparam logic [1:0] CPL_USER = 2'h3;

    // status, fault and interrupt fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_CARRY_BIT = 1;
    localparam int FLT_ERRV_BIT = 3;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_FAULT_BIT = 1;
    localparam int IRQ_W = 2;

    // access sizes less one, in bytes
    localparam logic [32:0] SPAN_WIDE = 33'h000000003;
    localparam logic [32:0] SPAN_NARROW = 33'h000000001;

    typedef enum logic [1:0] {OP_TEST, OP_COMPLEMENT, OP_CLEAR} bit_op_t;
    typedef enum logic [2:0] {
        FAULT_NONE, FAULT_GP, FAULT_SS, FAULT_PF, FAULT_AC, FAULT_UD
    } fault_t;

endpackage : bit_test_pkg
`default_nettype wire

// [logic/bit_test_modify_unit.sv]
// bit test, test-and-complement and test-and-clear execution unit behind AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module bit_test_modify_unit (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic mem_req,
    output logic mem_we,
    output logic mem_wide,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_page_fault,
    input wire logic [31:0] mem_fault_code,
    output logic irq
);
    import bit_test_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_READ, ST_WRITE, ST_FINISH} state_t;

    function automatic logic [31:0] apply_op(input logic [31:0] w, input logic [4:0] i,
                                             input bit_op_t op);
        logic [31:0] r;
        r = w;
        case (op)
            OP_COMPLEMENT: r[i] = ~w[i];
            OP_CLEAR: r[i] = 1'b0;
            default: r = w;
        endcase
        return r;
    endfunction : apply_op

    function automatic logic pick_bit(input logic [31:0] w, input logic [4:0] i);
        return w[i];
    endfunction : pick_bit

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0] rst_sync_reg;
    logic rst_n_int;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    state_t state_reg;
    logic [31:0] opcode_reg;
    logic [7:0] imm_reg;
    logic [31:0] offset_reg;
    logic [31:0] base_reg;
    logic [31:0] limit_reg;
    logic [7:0] seg_reg;
    logic [31:0] result_reg;
    logic carry_reg;
    logic old_bit_reg;
    fault_t fault_reg;
    logic err_valid_reg;
    logic [31:0] fault_code_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_enable_reg;
    logic [IRQ_W-1:0] irq_event;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rd_mux;
    logic busy;
    logic go_write;
    logic irq_clr_write;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    logic [7:0] op_first;
    logic [7:0] op_second;
    logic [2:0] op_regf;
    logic wide;
    logic mem_base;
    logic is_imm;
    logic legal;
    bit_op_t op_kind;
    logic [4:0] bit_idx;
    logic [31:0] disp;
    logic [31:0] byte_disp;
    logic [31:0] eff_addr;
    logic [32:0] last_byte;
    logic [1:0] mode;
    logic real_mode;
    logic prot_mode;
    logic misaligned;
    fault_t check_fault;

    assign op_first = opcode_reg[OPC_FIRST_LSB +: 8];
    assign op_second = opcode_reg[OPC_SECOND_LSB +: 8];
    assign op_regf = opcode_reg[OPC_REGF_LSB +: 3];
    assign wide = opcode_reg[OPC_WIDE_BIT];
    assign mem_base = opcode_reg[OPC_MEMBASE_BIT];
    assign is_imm = (op_second == OP2_GROUP_IMM);

    always_comb begin
        legal = 1'b0;
        op_kind = OP_TEST;
        if (op_first == OP_ESCAPE) begin
            case (op_second)
                OP2_TEST_REG: begin
                    legal = 1'b1;
                    op_kind = OP_TEST;
                end
                OP2_COMPL_REG: begin
                    legal = 1'b1;
                    op_kind = OP_COMPLEMENT;
                end
                OP2_CLEAR_REG: begin
                    legal = 1'b1;
                    op_kind = OP_CLEAR;
                end
                OP2_GROUP_IMM: begin
                    case (op_regf)
                        GRP_TEST: begin
                            legal = 1'b1;
                            op_kind = OP_TEST;
                        end
                        GRP_COMPL: begin
                            legal = 1'b1;
                            op_kind = OP_COMPLEMENT;
                        end
                        GRP_CLEAR: begin
                            legal = 1'b1;
                            op_kind = OP_CLEAR;
                        end
                        default: legal = 1'b0;
                    endcase
                end
                default: legal = 1'b0;
            endcase
        end
    end

    // higher immediate bits are dropped silently
    always_comb begin
        if (is_imm) begin
            bit_idx = wide ? imm_reg[4:0] : {2'b00, imm_reg[2:0]};
        end else begin
            bit_idx = wide ? offset_reg[4:0] : {1'b0, offset_reg[3:0]};
        end
    end

    // signed byte displacement, then rounded down to the access word
    assign byte_disp = 32'($signed(offset_reg) >>> 3);
    always_comb begin
        if (is_imm) begin
            disp = 32'h00000000;
        end else if (wide) begin
            disp = {byte_disp[31:2], 2'b00};
        end else begin
            disp = {byte_disp[31:1], 1'b0};
        end
    end
    assign eff_addr = base_reg + disp;
    assign last_byte = {1'b0, eff_addr} + (wide ? SPAN_WIDE : SPAN_NARROW);

    assign mode = seg_reg[SEG_MODE_LSB +: 2];
    assign real_mode = (mode == MODE_REAL);
    assign prot_mode = (mode == MODE_PROT);
    assign misaligned = wide ? (eff_addr[1:0] != 2'b00) : eff_addr[0];

    // segment faults first, then alignment; paging shows during the access
    always_comb begin
        check_fault = FAULT_NONE;
        if (prot_mode && seg_reg[SEG_NULL_BIT] && !seg_reg[SEG_STACK_BIT]) begin
            check_fault = FAULT_GP;
        end else if (last_byte > {1'b0, limit_reg}) begin
            if (seg_reg[SEG_STACK_BIT]) begin
                check_fault = FAULT_SS;
            end else begin
                check_fault = FAULT_GP;
            end
        end else if (prot_mode && op_kind != OP_TEST && !seg_reg[SEG_WRITABLE_BIT]) begin
            check_fault = FAULT_GP;
        end else if (!real_mode && seg_reg[SEG_ACEN_BIT] &&
                     seg_reg[SEG_CPL_LSB +: 2] == CPL_USER && misaligned) begin
            check_fault = FAULT_AC;
        end
    end

    assign busy = (state_reg != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
            wr_addr_reg <= haddr[7:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // only the low byte of the address decodes; the map aliases above it
    always_comb begin
        case (haddr[7:0])
            OFS_OPCODE: rd_mux = opcode_reg;
            OFS_IMM: rd_mux = {24'h000000, imm_reg};
            OFS_OFFSET: rd_mux = offset_reg;
            OFS_BASE: rd_mux = base_reg;
            OFS_LIMIT: rd_mux = limit_reg;
            OFS_SEG: rd_mux = {24'h000000, seg_reg};
            OFS_GO_STATUS: rd_mux = {30'h00000000, carry_reg, busy};
            OFS_RESULT: rd_mux = result_reg;
            OFS_FAULT: rd_mux = {28'h0000000, err_valid_reg, fault_reg};
            OFS_FAULT_CODE: rd_mux = fault_code_reg;
            OFS_IRQ_STATUS: rd_mux = {30'h00000000, irq_status_reg};
            OFS_IRQ_ENABLE: rd_mux = {30'h00000000, irq_enable_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    assign go_write = wr_pend_reg && (wr_addr_reg == OFS_GO_STATUS) && hwdata[0];
    assign irq_clr_write = wr_pend_reg && (wr_addr_reg == OFS_IRQ_CLEAR);

    ////////////////////////////////////////////////////////////////////////////
    // operand registers, frozen while an operation runs; the interrupt enable stays writable
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            opcode_reg <= 32'h00000000;
            imm_reg <= 8'h00;
            offset_reg <= 32'h00000000;
            base_reg <= 32'h00000000;
            limit_reg <= 32'h00000000;
            seg_reg <= 8'h00;
            irq_enable_reg <= '0;
        end else begin
            if (wr_pend_reg && wr_addr_reg == OFS_IRQ_ENABLE) begin
                irq_enable_reg <= hwdata[IRQ_W-1:0];
            end
            if (wr_pend_reg && !busy) begin
                case (wr_addr_reg)
                    OFS_OPCODE: opcode_reg <= hwdata;
                    OFS_IMM: imm_reg <= hwdata[7:0];
                    OFS_OFFSET: offset_reg <= hwdata;
                    OFS_BASE: base_reg <= hwdata;
                    OFS_LIMIT: limit_reg <= hwdata;
                    OFS_SEG: seg_reg <= hwdata[7:0];
                    default: opcode_reg <= opcode_reg;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer and datapath
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            state_reg <= ST_IDLE;
            result_reg <= 32'h00000000;
            carry_reg <= 1'b0;
            old_bit_reg <= 1'b0;
            fault_reg <= FAULT_NONE;
            err_valid_reg <= 1'b0;
            fault_code_reg <= 32'h00000000;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_wide <= 1'b0;
            mem_addr <= 32'h00000000;
            mem_wdata <= 32'h00000000;
            irq_event <= '0;
        end else begin
            irq_event <= '0;
            case (state_reg)
                ST_IDLE: begin
                    if (go_write) begin
                        state_reg <= ST_CHECK;
                        fault_reg <= FAULT_NONE;
                        err_valid_reg <= 1'b0;
                        fault_code_reg <= 32'h00000000;
                    end
                end
                ST_CHECK: begin
                    if (!legal) begin
                        fault_reg <= FAULT_UD;
                        state_reg <= ST_FINISH;
                    end else if (!mem_base) begin
                        // flags other than carry are never driven here
                        carry_reg <= pick_bit(base_reg, bit_idx);
                        result_reg <= apply_op(base_reg, bit_idx, op_kind);
                        state_reg <= ST_FINISH;
                    end else if (check_fault != FAULT_NONE) begin
                        fault_reg <= check_fault;
                        err_valid_reg <= !real_mode;
                        state_reg <= ST_FINISH;
                    end else begin
                        // a whole word is read even if one byte would do
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_wide <= wide;
                        mem_addr <= eff_addr;
                        state_reg <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        if (mem_page_fault && !real_mode) begin
                            fault_reg <= FAULT_PF;
                            err_valid_reg <= 1'b1;
                            fault_code_reg <= mem_fault_code;
                            state_reg <= ST_FINISH;
                        end else if (op_kind == OP_TEST) begin
                            carry_reg <= pick_bit(mem_rdata, bit_idx);
                            state_reg <= ST_FINISH;
                        end else begin
                            old_bit_reg <= pick_bit(mem_rdata, bit_idx);
                            mem_wdata <= apply_op(mem_rdata, bit_idx, op_kind);
                            mem_we <= 1'b1;
                            mem_req <= 1'b1;
                            state_reg <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        if (mem_page_fault && !real_mode) begin
                            fault_reg <= FAULT_PF;
                            err_valid_reg <= 1'b1;
                            fault_code_reg <= mem_fault_code;
                        end else begin
                            // carry commits only once the write has landed
                            carry_reg <= old_bit_reg;
                        end
                        state_reg <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    irq_event[IRQ_DONE_BIT] <= 1'b1;
                    irq_event[IRQ_FAULT_BIT] <= (fault_reg != FAULT_NONE);
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts; a new event beats a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            irq_status_reg <= '0;
            irq <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~(irq_clr_write ? hwdata[IRQ_W-1:0] : '0))
                              | irq_event;
            irq <= |(irq_status_reg & irq_enable_reg);
        end
    end

endmodule : bit_test_modify_unit
`default_nettype wire

// [verification/bit_test_properties.sv]
// checker: memory-side properties of the bit test unit
`timescale 1ns/1ps
`default_nettype none
module bit_test_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_wide,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd_ack;
        mem_req && !mem_we && mem_ack;
    endsequence
    sequence s_rd_then_req;
        s_rd_ack ##1 mem_req;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    AST_REQ_HOLD: assert property (
        mem_req && !mem_ack |=> mem_req && $stable({mem_we, mem_wide, mem_addr}))
        else $error("access moved before its acknowledge");
    AST_WDATA_HOLD: assert property (
        mem_req && mem_we && !mem_ack |=> $stable(mem_wdata))
        else $error("write data changed while waiting");
    AST_READ_FIRST: assert property ($rose(mem_req) |-> !mem_we)
        else $error("operation began with a write");
    AST_DROP_ON_ACK: assert property ($fell(mem_req) |-> $past(mem_ack))
        else $error("request dropped without acknowledge");
    AST_ONE_READ: assert property (s_rd_ack |=> !(mem_req && !mem_we))
        else $error("second read after an acknowledged read");
    AST_SAME_WORD: assert property (
        s_rd_then_req |-> mem_we && mem_addr == $past(mem_addr) && mem_wide == $past(mem_wide))
        else $error("write back went to another word");
    // clearing a clear bit changes nothing, hence at most one
    AST_ONE_BIT: assert property (
        s_rd_then_req |-> $countones((mem_wdata ^ $past(mem_rdata))
            & (mem_wide ? 32'hFFFFFFFF : 32'h0000FFFF)) <= 1)
        else $error("write back changed more than one bit");
    AST_WRITE_ONCE: assert property (
        mem_req && mem_we && mem_ack |=> !mem_req [*2])
        else $error("access continued after the write back");
endmodule : bit_test_properties
bind bit_test_modify_unit bit_test_properties chk_u (.core_clk(core_clk), .rst_n(rst_n),
    .mem_req(mem_req), .mem_we(mem_we), .mem_wide(mem_wide), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
`default_nettype wire

// [verification/bit_store_model.sv]
// far-side memory model answering the unit's bit string accesses
`timescale 1ns/1ps
`default_nettype none
module bit_store_model #(
    parameter logic [31:0] PAGE_CODE = 32'h0000002C
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] lat,
    input wire logic pf_en,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_wide,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    output logic mem_page_fault,
    output logic [31:0] mem_fault_code
);
    logic [7:0] mem [0:255];
    logic [3:0] wait_cnt;
    logic [7:0] a;
    assign a = mem_addr[7:0];
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            mem_page_fault <= 1'b0;
            mem_rdata <= 32'h00000000;
            mem_fault_code <= 32'h00000000;
            wait_cnt <= 4'h0;
        end else begin
            // released lines flip so stale data is never taken
            mem_ack <= 1'b0;
            mem_page_fault <= ~mem_page_fault;
            mem_rdata <= ~mem_rdata;
            mem_fault_code <= ~mem_fault_code;
            if (mem_req && !mem_ack) begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt >= lat) begin
                    wait_cnt <= 4'h0;
                    mem_ack <= 1'b1;
                    mem_page_fault <= pf_en;
                    mem_fault_code <= PAGE_CODE;
                    mem_rdata <= {mem[a + 8'h03], mem[a + 8'h02], mem[a + 8'h01], mem[a]};
                    for (int i = 0; i < 4; i++)
                        if (mem_we && (mem_wide || i < 2))
                            mem[a + 8'(i)] <= mem_wdata[8 * i +: 8];
                end
            end
        end
    end
endmodule : bit_store_model
`default_nettype wire

// [verification/tb_bit_test_modify_unit.sv]
// testbench: register bus tasks, bit operations, faults and interrupts
`timescale 1ns/1ps
`default_nettype none
module tb_bit_test_modify_unit;
    import bit_test_pkg::*;
    localparam logic [31:0] PF_CODE = 32'h0000002C;
    logic core_clk, rst_n, hsel, hwrite, hreadyout, hresp, irq, pf_en;
    logic mem_req, mem_we, mem_wide, mem_ack, mem_page_fault;
    logic [1:0] htrans;
    logic [3:0] lat;
    logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata, mem_fault_code, rv;
    int n_errors, checked, cycles;
    bit_test_modify_unit dut_u (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
        .mem_we(mem_we), .mem_wide(mem_wide), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_page_fault(mem_page_fault),
        .mem_fault_code(mem_fault_code), .irq(irq));
    bit_store_model #(.PAGE_CODE(PF_CODE)) mem_u (.core_clk(core_clk), .rst_n(rst_n), .lat(lat),
        .pf_en(pf_en), .mem_req(mem_req), .mem_we(mem_we), .mem_wide(mem_wide),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_page_fault(mem_page_fault), .mem_fault_code(mem_fault_code));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic addr_ph(input logic [7:0] a, input logic w);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
    endtask : addr_ph
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_ph(a, 1'b1);
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_ph(a, 1'b0);
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : rd
    function automatic logic [31:0] rdw(input int a);
        return {mem_u.mem[8'(a + 3)], mem_u.mem[8'(a + 2)], mem_u.mem[8'(a + 1)], mem_u.mem[8'(a)]};
    endfunction : rdw
    function automatic logic [31:0] opw(input int op, input int f, input int w, input int m);
        logic [7:0] sec [3];
        logic [2:0] grp [3];
        sec = '{8'hA3, 8'hBB, 8'hB3};
        grp = '{3'h4, 3'h7, 3'h6};
        return {6'h00, 1'(m), 1'(w), 5'h00, f ? grp[op] : 3'h0, f ? 8'hBA : sec[op], 8'h0F};
    endfunction : opw
    task automatic go(input logic [31:0] opc, imm, off, base, seg, lim);
        logic [31:0] v [6];
        v = '{opc, imm, off, base, lim, seg};
        for (int i = 0; i < 6; i++)
            wr(OFS_OPCODE + 8'(4 * i), v[i]);
        wr(OFS_GO_STATUS, 32'h1);
        rv = 32'h1;
        // bounded poll: a stuck busy flag fails, not hangs
        for (int i = 0; i < 40 && rv[ST_BUSY_BIT] !== 1'b0; i++)
            rd(OFS_GO_STATUS, rv);
        chk({31'h0, rv[ST_BUSY_BIT]}, 32'h0);
    endtask : go
    task automatic bit_op(input int op, input int f, input int w, input int m, input int b);
        logic [31:0] off, imm, base, word, msk, ew;
        int pos, ea, idx;
        off = b ? 32'd37 : 32'hFFFFFFF3;
        imm = b ? 32'h000000E5 : 32'h0000001B;
        base = m ? 32'h00000040 : 32'h5A5AC3A5;
        msk = w ? 32'hFFFFFFFF : 32'h0000FFFF;
        pos = f ? int'(w ? imm[4:0] : {2'h0, imm[2:0]}) : int'(off);
        pos = m ? pos + 8 * int'(base) : pos;
        ea = w ? (pos >>> 5) * 4 : (pos >>> 4) * 2;
        idx = w ? pos & 31 : pos & 15;
        word = m ? rdw(ea) : base;
        ew = op == 0 ? word : op == 1 ? word ^ (32'h1 << idx) : word & ~(32'h1 << idx);
        lat <= 4'(op + 2 * f);
        go(opw(op, f, w, m), imm, off, base, m ? 32'h11 : 32'h0, 32'hFF);
        rd(OFS_GO_STATUS, rv);
        chk({31'h0, rv[ST_CARRY_BIT]}, {31'h0, word[idx]});
        rd(OFS_RESULT, rv);
        chk((m ? rdw(ea) : rv) & msk, ew & msk);
        rd(OFS_FAULT, rv);
        chk(rv, 32'h0);
    endtask : bit_op
    task automatic flt(input logic [31:0] opc, base, seg, lim, input logic pf,
        input logic [3:0] ef);
        logic [31:0] prior;
        prior = rdw(int'(base));
        pf_en <= pf;
        go(opc, 32'h0, 32'h0, base, seg, lim);
        rd(OFS_FAULT, rv);
        chk(rv & 32'h0000000F, {28'h0, ef});
        rd(OFS_FAULT_CODE, rv);
        chk(rv, ef == 4'hB ? PF_CODE : 32'h0);
        chk(rdw(int'(base)), prior);
        pf_en <= 1'b0;
    endtask : flt
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        lat = 4'h0;
        pf_en = 1'b0;
        for (int k = 0; k < 256; k++)
            mem_u.mem[k] = 8'(k * 29 + 7);
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(OFS_IRQ_ENABLE, rv);
        chk(rv, 32'h0);
        wr(8'h80, 32'hFFFFFFFF);
        rd(8'h80, rv);
        chk(rv, 32'h0);
        $display("test register map done");
        for (int op = 0; op < 3; op++)
            for (int f = 0; f < 2; f++)
                for (int w = 0; w < 2; w++)
                    for (int m = 0; m < 2; m++)
                        for (int b = 0; b < 2; b++)
                            bit_op(op, f, w, m, b);
        $display("test bit operations done");
        flt(opw(0, 1, 1, 1), 32'h40, 32'h19, 32'hFF, 1'b0, 4'h9);
        flt(opw(0, 1, 1, 1), 32'h40, 32'h11, 32'h42, 1'b0, 4'h9);
        flt(opw(0, 1, 1, 1), 32'h40, 32'h15, 32'h42, 1'b0, 4'hA);
        flt(opw(0, 1, 1, 1), 32'h40, 32'h16, 32'h42, 1'b0, 4'hA);
        flt(opw(2, 1, 1, 1), 32'h40, 32'h01, 32'hFF, 1'b0, 4'h9);
        flt(opw(0, 1, 1, 1), 32'h41, 32'hF1, 32'hFF, 1'b0, 4'hC);
        flt(opw(2, 1, 1, 1), 32'h40, 32'h11, 32'hFF, 1'b1, 4'hB);
        flt(opw(0, 1, 1, 1), 32'h40, 32'h10, 32'h42, 1'b0, 4'h1);
        flt(opw(0, 1, 1, 1), 32'h40, 32'h10, 32'hFF, 1'b1, 4'h0);
        flt(32'h0305BA0F, 32'h40, 32'h11, 32'hFF, 1'b0, 4'h5);
        $display("test faults done");
        wr(OFS_IRQ_CLEAR, 32'h3);
        go(opw(1, 0, 1, 0), 32'h0, 32'h0, 32'h0, 32'h0, 32'hFF);
        rd(OFS_IRQ_STATUS, rv);
        chk(rv, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_ENABLE, 32'h3);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_CLEAR, 32'h1);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_IRQ_STATUS, rv);
        chk(rv, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("test interrupts done");
        results();
    end
endmodule : tb_bit_test_modify_unit
`default_nettype wire
